// *** hdl/avg_cal_pkg.sv ***
/*
  Constants shared by the channel average and calibrate datapath: register
  map, field layout, reset values, format and averaging encodings, timing.
  Assumes a parallel register write/read port that sits behind the serial
  control port decoder, and post-filter samples on the same clock.

//Operation
//[RULE1] Four-to-one mode averages all four channels
//[RULE2] Two-to-one mode averages channel pairs, two outputs
//[RULE3] Averaging works on post-filter output samples
//[RULE4] Pin control allows only four-to-one averaging
//[RULE5] Format field 11 enables averaging
//[RULE6] Bits three to two select averaging option
//[RULE7] Correction only under serial control, per channel
//[RULE8] Reset reloads factory coefficients, discarding writes
//[RULE9] Offset coefficient is 23-bit signed
//[RULE10] Offset applies only while its enable set
//[RULE11] Offset step moves output by two codes
//[RULE12] Gain coefficient 20 bits, plus/minus half
//[RULE13] Gain applies only while its select set
//[RULE14] Host sets rate slave, then interface reset
//[RULE15] Host resets all devices in one write
//[RULE16] Shared rate line keeps phase within 10 ns
//[RULE17] Format codes: 1-lane, 2-lane, parallel, averaging
//[RULE18] Pin averaging outputs result on lane zero
//[RULE19] Sum wide, arithmetic shift divides by count
//[RULE20] Offset then gain scaling, saturate to word
*/
package avg_cal_pkg;
  localparam int NUM_CHAN = 4;
  localparam int SAMPLE_W = 24;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int OFFSET_W = 23;
  localparam int GAIN_W = 20;
  localparam int GAIN_FRAC = 20;
  localparam int COUNT_W = 3;

  // Register addresses
  localparam logic [6:0] ADDR_FORMAT_CTRL = 7'h12;
  localparam logic [6:0] ADDR_REINIT = 7'h13;
  localparam logic [6:0] ADDR_STATUS = 7'h14;
  localparam logic [6:0] ADDR_CAL_BASE = 7'h20;
  localparam logic [6:0] ADDR_CAL_LAST = 7'h3f;
  localparam int CAL_STRIDE_LSB = 3;
  localparam logic [2:0] CAL_CTRL = 3'h0;
  localparam logic [2:0] CAL_OFF_B0 = 3'h1;
  localparam logic [2:0] CAL_OFF_B2 = 3'h3;
  localparam logic [2:0] CAL_GAIN_B0 = 3'h4;
  localparam logic [2:0] CAL_GAIN_B2 = 3'h6;

  // Field positions
  localparam int FMT_LSB = 0;
  localparam int AVERAGE_OPTION_SELECT_LSB = 2;
  localparam int REINIT_BIT = 0;
  localparam int OFF_ON_BIT = 0;
  localparam int GAIN_ON_BIT = 1;

  localparam logic [7:0] FORMAT_CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    FMT_ONE_LANE = 2'b00,
    FMT_TWO_LANE = 2'b01,
    FMT_PARALLEL = 2'b10,
    FMT_AVERAGE = 2'b11
  } out_format_t;

  typedef enum logic [1:0] {
    AVG_FOUR = 2'b00,
    AVG_TWO = 2'b01,
    AVG_TWO_ALT = 2'b10,
    AVG_FOUR_ALT = 2'b11
  } avg_opt_t;

  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  // Interface re-init pulse: held for the phase budget, at least one cycle
  localparam int CLK_PERIOD_NS = 40;
  localparam int PHASE_MATCH_NS = 10;
  localparam int REINIT_CYCLES_RAW = PHASE_MATCH_NS / CLK_PERIOD_NS;
  localparam int REINIT_CYCLES = (REINIT_CYCLES_RAW < 1) ? 1 : REINIT_CYCLES_RAW;
endpackage : avg_cal_pkg

// *** hdl/pair_buffer.sv ***
/*
  Two-entry buffer with valid/ready on both sides and a flush input.
  Assumes one clock; output data and valid come straight from registers.
*/
`timescale 1ns/1ns
`default_nettype none
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic out_v_r, out_v_nxt, skid_v_r, skid_v_nxt;
  logic [WIDTH-1:0] out_d_r, out_d_nxt, skid_d_r, skid_d_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid_i && !skid_v_r;
    pop = out_v_r && out_ready_i;
    out_v_nxt = out_v_r;
    out_d_nxt = out_d_r;
    skid_v_nxt = skid_v_r;
    skid_d_nxt = skid_d_r;
    if (!out_v_r || pop) begin
      if (skid_v_r) begin
        out_v_nxt = 1'b1;
        out_d_nxt = skid_d_r;
        skid_v_nxt = 1'b0;
      end else if (push) begin
        out_v_nxt = 1'b1;
        out_d_nxt = in_data_i;
      end else begin
        out_v_nxt = 1'b0;
      end
    end else if (push) begin
      skid_v_nxt = 1'b1;
      skid_d_nxt = in_data_i;
    end
    if (flush_i) begin
      out_v_nxt = 1'b0;
      skid_v_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      out_d_r <= '0;
      skid_d_r <= '0;
    end else if (ce_i) begin
      out_v_r <= out_v_nxt;
      skid_v_r <= skid_v_nxt;
      out_d_r <= out_d_nxt;
      skid_d_r <= skid_d_nxt;
    end
  end

  assign in_ready_o = !skid_v_r;
  assign out_valid_o = out_v_r;
  assign out_data_o = out_d_r;
endmodule : pair_buffer
`default_nettype wire

// *** hdl/channel_average_calibrate.sv ***
/*
  Post-filter datapath: per-channel offset/gain correction, 2:1 or 4:1
  channel averaging, output format selection and digital interface re-init.
  Assumes filtered samples arrive on ref_clk_i with valid/ready, registers
  are written through a parallel port behind the serial control decoder,
  and the control-mode and format strap pins are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module channel_average_calibrate
  import avg_cal_pkg::*;
#(
  parameter logic [avg_cal_pkg::NUM_CHAN*avg_cal_pkg::OFFSET_W-1:0] FACTORY_OFFSET = '0,
  parameter logic [avg_cal_pkg::NUM_CHAN*avg_cal_pkg::GAIN_W-1:0] FACTORY_GAIN = '0
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic spi_mode_pin_i,
  input wire logic format_strap_low_i,
  input wire logic format_strap_high_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [avg_cal_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [avg_cal_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [avg_cal_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [avg_cal_pkg::NUM_CHAN*avg_cal_pkg::SAMPLE_W-1:0] sample_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [avg_cal_pkg::NUM_CHAN*avg_cal_pkg::SAMPLE_W-1:0] out_lanes_o,
  output logic [avg_cal_pkg::COUNT_W-1:0] out_chan_count_o,
  output logic sample_port_reinit_o
);
  import avg_cal_pkg::*;

  localparam int LANES_W = NUM_CHAN * SAMPLE_W;
  localparam int BUF_W = LANES_W + COUNT_W;
  localparam int SUM_W = SAMPLE_W + 2;
  localparam int OFFS_W = SAMPLE_W + 3;
  localparam int PROD_W = OFFS_W + GAIN_W;
  localparam int CORR_W = OFFS_W + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Coefficient address: channel index and field within the channel block
  function automatic logic cal_hit(input logic [ADDR_W-1:0] addr);
    cal_hit = (addr >= ADDR_CAL_BASE) && (addr <= ADDR_CAL_LAST);
  endfunction : cal_hit

  function automatic logic [1:0] cal_chan(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - ADDR_CAL_BASE;
    cal_chan = rel[CAL_STRIDE_LSB +: 2];
  endfunction : cal_chan

  function automatic logic [2:0] cal_field(input logic [ADDR_W-1:0] addr);
    cal_field = addr[CAL_STRIDE_LSB-1:0];
  endfunction : cal_field

  // Offset of twice the coefficient, then gain of 1 + g * 2^-20, saturated
  function automatic logic [SAMPLE_W-1:0] correct(
    input logic [SAMPLE_W-1:0] x,
    input logic [OFFSET_W-1:0] off,
    input logic [GAIN_W-1:0] gain,
    input logic off_on,
    input logic gain_on
  );
    logic signed [OFFS_W-1:0] s;
    logic signed [PROD_W-1:0] prod;
    logic signed [CORR_W-1:0] y;
    logic signed [CORR_W-1:0] max_v;
    logic signed [CORR_W-1:0] min_v;
    s = OFFS_W'($signed(x));
    if (off_on) begin
      s = s + OFFS_W'($signed({off, 1'b0}));  // [RULE10] [RULE11] [RULE9]
    end
    y = CORR_W'(s);
    if (gain_on) begin
      prod = PROD_W'(s) * PROD_W'($signed(gain));  // [RULE12] [RULE13]
      y = y + CORR_W'(prod >>> GAIN_FRAC);  // [RULE20]
    end
    max_v = CORR_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    min_v = -max_v - CORR_W'(1);
    if (y > max_v) begin
      correct = max_v[SAMPLE_W-1:0];  // [RULE20]
    end else if (y < min_v) begin
      correct = min_v[SAMPLE_W-1:0];
    end else begin
      correct = y[SAMPLE_W-1:0];
    end
  endfunction : correct

  // Signed sum at extended width, divided by arithmetic shift
  function automatic logic [SAMPLE_W-1:0] average(
    input logic [SAMPLE_W-1:0] a,
    input logic [SAMPLE_W-1:0] b,
    input logic [SAMPLE_W-1:0] c,
    input logic [SAMPLE_W-1:0] d,
    input logic four
  );
    logic signed [SUM_W-1:0] sum;
    sum = SUM_W'($signed(a)) + SUM_W'($signed(b));
    if (four) begin
      sum = sum + SUM_W'($signed(c)) + SUM_W'($signed(d));
      sum = sum >>> 2;  // [RULE19]
    end else begin
      sum = sum >>> 1;  // [RULE19]
    end
    average = sum[SAMPLE_W-1:0];
  endfunction : average

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pin_meta_r, pin_sync_r;
  logic spi_mode, strap_low, strap_high;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else if (ce_i) begin
      pin_meta_r <= {format_strap_high_i, format_strap_low_i, spi_mode_pin_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign spi_mode = pin_sync_r[0];
  assign strap_low = pin_sync_r[1];
  assign strap_high = pin_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [DATA_W-1:0] fmt_ctrl_r, fmt_ctrl_nxt;
  logic [NUM_CHAN-1:0] off_on_r, off_on_nxt, gain_on_r, gain_on_nxt;
  logic [OFFSET_W-1:0] off_r [NUM_CHAN], off_nxt [NUM_CHAN];
  logic [GAIN_W-1:0] gain_r [NUM_CHAN], gain_nxt [NUM_CHAN];
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [$clog2(REINIT_CYCLES+1)-1:0] reinit_cnt_r, reinit_cnt_nxt;
  logic reinit_r, reinit_nxt;
  logic buf_full;
  logic [1:0] wch, rch;
  logic [2:0] wfld, rfld;
  logic [23:0] off_ext, gain_ext;

  always_comb begin
    fmt_ctrl_nxt = fmt_ctrl_r;
    off_on_nxt = off_on_r;
    gain_on_nxt = gain_on_r;
    off_nxt = off_r;
    gain_nxt = gain_r;
    reinit_cnt_nxt = reinit_cnt_r;
    wch = cal_chan(reg_addr_i);
    wfld = cal_field(reg_addr_i);
    off_ext = {1'b0, off_r[wch]};
    gain_ext = {4'h0, gain_r[wch]};
    if (reinit_cnt_r != '0) begin
      reinit_cnt_nxt = reinit_cnt_r - 1'b1;
    end
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_FORMAT_CTRL) begin
        fmt_ctrl_nxt = reg_wdata_i;  // [RULE5] [RULE6]
      end else if (reg_addr_i == ADDR_REINIT && reg_wdata_i[REINIT_BIT]) begin
        reinit_cnt_nxt = ($clog2(REINIT_CYCLES+1))'(REINIT_CYCLES);  // [RULE16] [RULE14]
      end else if (cal_hit(reg_addr_i)) begin
        if (wfld == CAL_CTRL) begin
          off_on_nxt[wch] = reg_wdata_i[OFF_ON_BIT];
          gain_on_nxt[wch] = reg_wdata_i[GAIN_ON_BIT];
        end else if (wfld >= CAL_OFF_B0 && wfld <= CAL_OFF_B2) begin
          off_ext[(wfld - CAL_OFF_B0)*DATA_W +: DATA_W] = reg_wdata_i;
          off_nxt[wch] = off_ext[OFFSET_W-1:0];  // [RULE9]
        end else if (wfld >= CAL_GAIN_B0 && wfld <= CAL_GAIN_B2) begin
          gain_ext[(wfld - CAL_GAIN_B0)*DATA_W +: DATA_W] = reg_wdata_i;
          gain_nxt[wch] = gain_ext[GAIN_W-1:0];  // [RULE12]
        end
      end
    end
    reinit_nxt = (reinit_cnt_nxt != '0);
  end

  always_comb begin
    rdata_nxt = rdata_r;
    rch = cal_chan(reg_addr_i);
    rfld = cal_field(reg_addr_i);
    if (reg_rd_i) begin
      rdata_nxt = READ_ZERO;
      if (reg_addr_i == ADDR_FORMAT_CTRL) begin
        rdata_nxt = fmt_ctrl_r;
      end else if (reg_addr_i == ADDR_STATUS) begin
        rdata_nxt = {4'h0, buf_full, strap_high, strap_low, spi_mode};
      end else if (cal_hit(reg_addr_i)) begin
        case (rfld)
          CAL_CTRL: rdata_nxt = {6'h00, gain_on_r[rch], off_on_r[rch]};
          3'h1: rdata_nxt = off_r[rch][7:0];
          3'h2: rdata_nxt = off_r[rch][15:8];
          3'h3: rdata_nxt = {1'b0, off_r[rch][22:16]};
          3'h4: rdata_nxt = gain_r[rch][7:0];
          3'h5: rdata_nxt = gain_r[rch][15:8];
          3'h6: rdata_nxt = {4'h0, gain_r[rch][19:16]};
          default: rdata_nxt = READ_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fmt_ctrl_r <= FORMAT_CTRL_RESET;
      off_on_r <= '0;
      gain_on_r <= '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        off_r[c] <= FACTORY_OFFSET[c*OFFSET_W +: OFFSET_W];  // [RULE8]
        gain_r[c] <= FACTORY_GAIN[c*GAIN_W +: GAIN_W];  // [RULE8]
      end
      rdata_r <= READ_ZERO;
      reinit_cnt_r <= '0;
      reinit_r <= 1'b0;
    end else if (ce_i) begin
      fmt_ctrl_r <= fmt_ctrl_nxt;
      off_on_r <= off_on_nxt;
      gain_on_r <= gain_on_nxt;
      off_r <= off_nxt;
      gain_r <= gain_nxt;
      rdata_r <= rdata_nxt;
      reinit_cnt_r <= reinit_cnt_nxt;
      reinit_r <= reinit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode

  logic [1:0] eff_format;
  logic avg_four;

  always_comb begin
    if (spi_mode) begin
      eff_format = fmt_ctrl_r[FMT_LSB +: 2];  // [RULE5]
      avg_four = (fmt_ctrl_r[AVERAGE_OPTION_SELECT_LSB +: 2] == AVG_FOUR)
        || (fmt_ctrl_r[AVERAGE_OPTION_SELECT_LSB +: 2] == AVG_FOUR_ALT);  // [RULE6]
    end else begin
      eff_format = {strap_high, strap_low};
      avg_four = 1'b1;  // [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Correction stage

  logic [SAMPLE_W-1:0] corr_w [NUM_CHAN];
  logic [SAMPLE_W-1:0] st_data_r [NUM_CHAN], st_data_nxt [NUM_CHAN];
  logic st_valid_r, st_valid_nxt, ready_r, ready_nxt;
  logic buf_in_ready, take, push;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_corr
      assign corr_w[g] = correct(sample_data_i[g*SAMPLE_W +: SAMPLE_W], off_r[g],
        gain_r[g], off_on_r[g] && spi_mode, gain_on_r[g] && spi_mode);  // [RULE7]
    end
  endgenerate

  always_comb begin
    take = sample_valid_i && ready_r;
    push = st_valid_r && buf_in_ready;
    st_valid_nxt = st_valid_r;
    st_data_nxt = st_data_r;
    if (push) begin
      st_valid_nxt = 1'b0;
    end
    if (take) begin
      st_valid_nxt = 1'b1;
      st_data_nxt = corr_w;
    end
    if (reinit_r) begin
      st_valid_nxt = 1'b0;  // [RULE16]
    end
    ready_nxt = !st_valid_nxt && !reinit_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_valid_r <= 1'b0;
      ready_r <= 1'b0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        st_data_r[c] <= '0;
      end
    end else if (ce_i) begin
      st_valid_r <= st_valid_nxt;
      ready_r <= ready_nxt;
      st_data_r <= st_data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averaging and lane mapping

  logic [LANES_W-1:0] lanes;
  logic [COUNT_W-1:0] chan_count;

  always_comb begin
    lanes = '0;
    chan_count = CNT_FOUR;
    case (eff_format)
      FMT_AVERAGE: begin
        if (avg_four) begin
          lanes[0 +: SAMPLE_W] = average(st_data_r[0], st_data_r[1],
            st_data_r[2], st_data_r[3], 1'b1);  // [RULE1] [RULE18] [RULE3]
          chan_count = CNT_ONE;
        end else begin
          lanes[0 +: SAMPLE_W] = average(st_data_r[0], st_data_r[1],
            st_data_r[0], st_data_r[1], 1'b0);  // [RULE2]
          lanes[SAMPLE_W +: SAMPLE_W] = average(st_data_r[2], st_data_r[3],
            st_data_r[2], st_data_r[3], 1'b0);  // [RULE2]
          chan_count = CNT_TWO;
        end
      end
      FMT_ONE_LANE, FMT_TWO_LANE, FMT_PARALLEL: begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          lanes[c*SAMPLE_W +: SAMPLE_W] = st_data_r[c];  // [RULE17]
        end
      end
      default: begin
        lanes = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer

  logic [BUF_W-1:0] buf_out;

  pair_buffer #(
    .WIDTH(BUF_W)
  ) pair_buffer_i (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .flush_i(reinit_r),
    .in_valid_i(st_valid_r),
    .in_ready_o(buf_in_ready),
    .in_data_i({chan_count, lanes}),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(buf_out)
  );

  assign buf_full = !buf_in_ready;
  assign out_lanes_o = buf_out[LANES_W-1:0];
  assign out_chan_count_o = buf_out[BUF_W-1 -: COUNT_W];
  assign sample_ready_o = ready_r;
  assign reg_rdata_o = rdata_r;
  assign sample_port_reinit_o = reinit_r;
endmodule : channel_average_calibrate
`default_nettype wire

// *** verif/avg_cal_monitor.sv ***
/*
  Port assertions for the channel average and calibrate datapath.
  Assumes one clock, asynchronous active-low reset, bound to the top module.
*/
`timescale 1ns/1ns
`default_nettype none
module avg_cal_monitor
  import avg_cal_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [avg_cal_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [avg_cal_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic [avg_cal_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire logic sample_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [avg_cal_pkg::NUM_CHAN*avg_cal_pkg::SAMPLE_W-1:0] out_lanes_o,
  input wire logic [avg_cal_pkg::COUNT_W-1:0] out_chan_count_o,
  input wire logic sample_port_reinit_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    sample_valid_i && sample_ready_o && ce_i;
  endsequence
  sequence s_reinit_wr;
    reg_wr_i && ce_i && reg_addr_i == ADDR_REINIT && reg_wdata_i[REINIT_BIT];
  endsequence
  sequence s_fmt_wr;
    reg_wr_i && ce_i && reg_addr_i == ADDR_FORMAT_CTRL;
  endsequence
  sequence s_fmt_rd;
    reg_rd_i && ce_i && reg_addr_i == ADDR_FORMAT_CTRL && !reg_wr_i;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  reinit_pulse_a: assert property (s_reinit_wr |=> sample_port_reinit_o)
    else $error("interface re-init pulse missing");
  reinit_single_a: assert property (sample_port_reinit_o && ce_i && !reg_wr_i |=>
    !sample_port_reinit_o) else $error("re-init pulse longer than one cycle");
  reinit_block_a: assert property (sample_port_reinit_o |-> !sample_ready_o)
    else $error("sample accepted during re-init");
  take_gap_a: assert property (s_take |=> !sample_ready_o)
    else $error("two samples accepted back to back");
  out_hold_a: assert property (out_valid_o && !out_ready_i && !reg_wr_i &&
    !sample_port_reinit_o |=> out_valid_o && $stable(out_lanes_o) && $stable(out_chan_count_o))
    else $error("output word changed while stalled");
  avg_four_a: assert property (out_valid_o && out_chan_count_o == CNT_ONE |->
    out_lanes_o[NUM_CHAN*SAMPLE_W-1:SAMPLE_W] == '0) else $error("4:1 result not on lane zero only");
  avg_two_a: assert property (out_valid_o && out_chan_count_o == CNT_TWO |->
    out_lanes_o[NUM_CHAN*SAMPLE_W-1:2*SAMPLE_W] == '0) else $error("2:1 uses more than two lanes");
  fmt_back_a: assert property (s_fmt_wr ##2 s_fmt_rd |=>
    reg_rdata_o == $past(reg_wdata_i, 3)) else $error("format control readback wrong");
endmodule : avg_cal_monitor

bind channel_average_calibrate avg_cal_monitor avg_cal_monitor_i (.ref_clk_i, .rstn_i, .ce_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .sample_valid_i,
  .sample_ready_o, .out_valid_o, .out_ready_i, .out_lanes_o, .out_chan_count_o,
  .sample_port_reinit_o);
`default_nettype wire

// *** verif/host_sink_model.sv ***
/*
  Host side taking the output stream; keeps the last 32 accepted words in order.
  Assumes the datapath clock; mode_i is set by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module host_sink_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i,
  input wire logic valid_i,
  input wire logic [95:0] lanes_i,
  input wire logic [2:0] count_i,
  output logic ready_o,
  output int rx_count_o
);
  logic [98:0] got_r [0:31];
  logic [1:0] tick_r;
  initial rx_count_o = 0;
  // Mode 0 always ready, 1 ready one cycle in three, 2 stalls
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_o <= 1'b0;
      tick_r <= 2'h0;
    end else begin
      tick_r <= (tick_r == 2'h2) ? 2'h0 : tick_r + 2'h1;
      ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && tick_r == 2'h0);
    end
  end
  always @(posedge clk_i) begin
    if (rstn_i && valid_i && ready_o) begin
      got_r[rx_count_o[4:0]] <= {count_i, lanes_i};
      rx_count_o <= rx_count_o + 1;
    end
  end
endmodule : host_sink_model
`default_nettype wire

// *** verif/tb_channel_average_calibrate.sv ***
/*
  Self-checking bench: register and sample tasks, host_sink_model as consumer.
  Assumes a 25 MHz clock and the register map of avg_cal_pkg.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_channel_average_calibrate;
  import avg_cal_pkg::*;
  localparam logic [95:0] S = 96'hfffffc_00000d_fffffe_ffffff;
  localparam logic [95:0] X = {4{24'd400}};
  localparam logic [14:0] CAL [8] = '{15'h21ff, 15'h22ff, 15'h23ff, 15'h2802,
    15'h2e04, 15'h3604, 15'h3964, 15'h2e04};
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic spi_mode_pin_i = 1'b1;
  logic format_strap_low_i = 1'b0;
  logic format_strap_high_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic sample_valid_i = 1'b0;
  logic sample_ready_o;
  logic [95:0] sample_data_i = 96'h0;
  logic out_valid_o;
  logic out_ready_i;
  logic [95:0] out_lanes_o;
  logic [2:0] out_chan_count_o;
  logic sample_port_reinit_o;
  logic [1:0] mode = 2'h0;
  logic [2:0] k;
  int rx_count;
  int rx_idx = 0;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  channel_average_calibrate #(.FACTORY_OFFSET(92'h5)) channel_average_calibrate_i (.ref_clk_i,
    .rstn_i, .ce_i, .spi_mode_pin_i, .format_strap_low_i, .format_strap_high_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .sample_valid_i, .sample_ready_o,
    .sample_data_i, .out_valid_o, .out_ready_i, .out_lanes_o, .out_chan_count_o,
    .sample_port_reinit_o);
  host_sink_model host_sink_model_i (.clk_i(ref_clk_i), .rstn_i(rstn_i), .mode_i(mode),
    .valid_i(out_valid_o), .lanes_i(out_lanes_o), .count_i(out_chan_count_o),
    .ready_o(out_ready_i), .rx_count_o(rx_count));

  always #20 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [95:0] avg_of(input logic [95:0] s, input logic [2:0] n);
    logic signed [25:0] a [4];
    for (int i = 0; i < 4; i++) a[i] = $signed(s[24*i +: 24]);
    if (n == CNT_TWO) return {48'h0, 24'((a[2] + a[3]) >>> 1), 24'((a[0] + a[1]) >>> 1)};
    return {72'h0, 24'((a[0] + a[1] + a[2] + a[3]) >>> 2)};
  endfunction : avg_of
  task automatic final_report();
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic reset_dut();
    rstn_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : reset_dut
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] ex);
    @(posedge ref_clk_i);
    #1 reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_rd_i = 1'b0;
    `CHK("rdata", ex, reg_rdata_o)
  endtask : rd_chk
  task automatic send(input logic [95:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    #1 sample_data_i = d;
    sample_valid_i = 1'b1;
    while (sample_ready_o !== 1'b1 && n < 60) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    @(posedge ref_clk_i);
    #1 sample_valid_i = 1'b0;
    sample_data_i = ~d;
    if (n == 60) fails++;
  endtask : send
  task automatic expect_word(input logic [95:0] l, input logic [2:0] c);
    int n;
    n = 0;
    while (rx_count <= rx_idx && n < 60) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    `CHK("word", {c, l}, host_sink_model_i.got_r[rx_idx[4:0]])
    rx_idx++;
  endtask : expect_word
  task automatic xfer(input logic [95:0] d, input logic [95:0] l, input logic [2:0] c);
    send(d);
    expect_word(l, c);
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    reset_dut();
    rd_chk(ADDR_FORMAT_CTRL, FORMAT_CTRL_RESET);
    rd_chk(7'h21, 8'h05);
    rd_chk(ADDR_REINIT, READ_ZERO);
    rd_chk(7'h7f, READ_ZERO);
    for (int f = 0; f < 3; f++) begin
      wr(ADDR_FORMAT_CTRL, 8'(f));
      xfer(S, S, CNT_FOUR);
    end
    for (int v = 0; v < 4; v++) begin
      k = (v == 1 || v == 2) ? CNT_TWO : CNT_ONE;
      wr(ADDR_FORMAT_CTRL, 8'(4 * v + 3));
      rd_chk(ADDR_FORMAT_CTRL, 8'(4 * v + 3));
      xfer(S, avg_of(S, k), k);
    end
    wr(ADDR_FORMAT_CTRL, 8'h00);
    wr(7'h20, 8'h01);
    xfer(X, {X[95:24], 24'd410}, CNT_FOUR);
    foreach (CAL[i]) wr(CAL[i][14:8], CAL[i][7:0]);
    rd_chk(7'h23, 8'h7f);
    rd_chk(7'h2e, 8'h04);
    xfer(X, {24'd400, 24'd400, 24'd500, 24'd398}, CNT_FOUR);
    spi_mode_pin_i = 1'b0;
    format_strap_low_i = 1'b1;
    format_strap_high_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    xfer(S, avg_of(S, CNT_ONE), CNT_ONE);
    format_strap_low_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    xfer(S, S, CNT_FOUR);
    #1 spi_mode_pin_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    wr(ADDR_REINIT, 8'h01);
    `CHK("reinit", 1'b1, sample_port_reinit_o)
    rd_chk(ADDR_REINIT, READ_ZERO);
    ce_i = 1'b0;
    wr(ADDR_FORMAT_CTRL, 8'h55);
    ce_i = 1'b1;
    rd_chk(ADDR_FORMAT_CTRL, 8'h00);
    reset_dut();
    rd_chk(7'h21, 8'h05);
    rd_chk(7'h23, 8'h00);
    mode = 2'h2;
    for (int i = 1; i < 4; i++) send({4{24'(i)}});
    repeat (6) @(posedge ref_clk_i);
    #1 `CHK("refuse", 1'b0, sample_ready_o)
    rd_chk(ADDR_STATUS, 8'h0d);
    mode = 2'h1;
    send({4{24'd4}});
    for (int i = 1; i < 5; i++) expect_word({4{24'(i)}}, CNT_FOUR);
    final_report();
  end
endmodule : tb_channel_average_calibrate
`default_nettype wire
